// file: hw/ops_map.vh
// register map, field positions and timing constants of the output protection supervisor
`ifndef OPS_MAP_VH
`define OPS_MAP_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OPS_REG_CTRL     8'h00
`define OPS_REG_OCPCFG   8'h04
`define OPS_REG_DELAY    8'h08
`define OPS_REG_OUTPUT   8'h0C
`define OPS_REG_CLEAR    8'h10
`define OPS_REG_STATUS   8'h14
`define OPS_REG_SYSST    8'h18
`define OPS_REG_ERRQ     8'h1C
`define OPS_REG_SLOT     8'h20
`define OPS_REG_GROUP    8'h24
`define OPS_REG_REBOOT   8'h28
`define OPS_REG_VSET     8'h30
`define OPS_REG_ISET     8'h40
`define OPS_SET_MASK     8'hF0

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define OPS_CTRL_COUPLE  0
`define OPS_CTRL_PON     1
`define OPS_SLOT_SEL     0
`define OPS_SLOT_SAVE    1
`define OPS_SLOT_RECALL  2
`define OPS_F_OVERV      0
`define OPS_F_OVERI      1
`define OPS_F_TEMP       2
`define OPS_F_MAINS      3
`define OPS_F_PLIM       4
`define OPS_F_COUPLED    5
`define OPS_F_EXTSD      6
`define OPS_NFLAG        7
`define OPS_ERR_BASE     8'h10
`define OPS_RESP_OKAY    2'b00
`define OPS_RESP_SLVERR  2'b10
`define OPS_DELAY_RST    16'h0000
`define OPS_SET_RST      16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define OPS_CLK_MHZ      50
`define OPS_TICK_NS      1000
`define OPS_TICK_CYC     ((`OPS_TICK_NS * `OPS_CLK_MHZ) / 1000)
`define OPS_COARSE_TICKS 1000
`define OPS_SELFTEST_CYC 16
// last count values, sized for their counters
`define OPS_TICK_LAST    6'h31
`define OPS_COARSE_LAST  10'h3E7
`define OPS_SELFTEST_LAST 5'h0F

`endif

// file: hw/ops_chan.v
// one output channel: fault latches, current guard delay timer and output gate
`timescale 1ns/1ns
`include "ops_map.vh"

module ops_chan (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // configuration
  input  wire        out_req,
  input  wire        ocp_en,
  input  wire        delay_on_regulation_entry,
  input  wire [15:0] delay,
  input  wire        tick,
  input  wire        set_chg,
  input  wire        clear,
  // conditions from the output stage; coupled trip from the other channels
  input  wire        current_regulation_state,
  input  wire        overvoltage_guard,
  input  wire        overtemp,
  input  wire        mains_fail,
  input  wire        power_limit,
  input  wire        external_shutdown,
  input  wire        coupled_trip,
  // results
  output reg  [6:0]  flags_ff,
  output reg         out_en_ff
);

  reg        reg_prev_ff;
  reg        run_ff;
  reg [15:0] cnt_ff;
  reg        nxt_run;
  reg [15:0] nxt_cnt;
  reg [6:0]  nxt_flags;
  reg        start;
  reg        expired;
  reg        ilim_trip;

  wire entry    = current_regulation_state & ~reg_prev_ff;
  wire leave    = ~current_regulation_state & reg_prev_ff;
  wire ilim     = ocp_en & out_en_ff & current_regulation_state;
  wire dly_nz   = (delay != `OPS_DELAY_RST);

  always @* begin
    // entry option: every entry; setting option: only setting changes
    start     = delay_on_regulation_entry ? entry : set_chg;
    expired   = run_ff & tick & (cnt_ff + 16'h0001 >= delay);
    // no running or starting timer means no grace at all
    ilim_trip = ilim & (expired | (~run_ff & ~(start & dly_nz)));
    nxt_run   = run_ff;
    nxt_cnt   = cnt_ff;
    if (start && dly_nz) begin
      nxt_run = 1'b1;
      nxt_cnt = 16'h0000;
    end else if (run_ff && leave) begin
      nxt_run = 1'b0;
    end else if (expired) begin
      nxt_run = 1'b0;
    end else if (run_ff && tick) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
    // set wins over clear, so a live cause re-latches at once
    nxt_flags = clear ? 7'h00 : flags_ff;
    if (overvoltage_guard) nxt_flags[`OPS_F_OVERV] = 1'b1;
    if (ilim_trip)         nxt_flags[`OPS_F_OVERI] = 1'b1;
    if (overtemp)          nxt_flags[`OPS_F_TEMP] = 1'b1;
    if (mains_fail)        nxt_flags[`OPS_F_MAINS] = 1'b1;
    if (power_limit)       nxt_flags[`OPS_F_PLIM] = 1'b1;
    if (coupled_trip)      nxt_flags[`OPS_F_COUPLED] = 1'b1;
    if (external_shutdown) nxt_flags[`OPS_F_EXTSD] = 1'b1;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_prev_ff <= 1'b0;
      run_ff      <= 1'b0;
      cnt_ff      <= 16'h0000;
      flags_ff    <= 7'h00;
      out_en_ff   <= 1'b0;
    end else begin
      reg_prev_ff <= current_regulation_state;
      run_ff      <= nxt_run;
      cnt_ff      <= nxt_cnt;
      flags_ff    <= nxt_flags;
      out_en_ff   <= out_req & ~(|nxt_flags);
    end
  end

endmodule

// file: hw/ops_top.v
// output protection supervisor top: AXI4-Lite registers, boot, slots, groups, four channels
`timescale 1ns/1ns
`include "ops_map.vh"

module ops_top (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // AXI4-Lite write address / data / response
  input  wire [7:0]   s_axi_awaddr,
  input  wire         s_axi_awvalid,
  output wire         s_axi_awready,
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  input  wire         s_axi_wvalid,
  output wire         s_axi_wready,
  output reg  [1:0]   s_axi_bresp,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]   s_axi_araddr,
  input  wire         s_axi_arvalid,
  output wire         s_axi_arready,
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready,
  // output stage conditions, one bit per channel
  input  wire [3:0]   current_regulation_state,
  input  wire [3:0]   overvoltage_guard,
  input  wire [3:0]   overtemp,
  input  wire [3:0]   mains_fail,
  input  wire [3:0]   power_limit,
  input  wire [3:0]   external_shutdown,
  input  wire [3:0]   selftest_fault,
  // output stage controls and indicators
  output wire [3:0]   out_enable,
  output wire [63:0]  vset,
  output wire [63:0]  iset,
  output wire [3:0]   prot_indicator,
  output wire         err_indicator
);

  localparam BOOT_TEST   = 2'd0;
  localparam BOOT_RECALL = 2'd1;
  localparam BOOT_RUN    = 2'd2;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          wmerge[8*b +: 8] = nw[8*b +: 8];
    end
  endfunction

  // grouped members see the OR of the whole group
  function grp_or;
    input [3:0] vec;
    input [3:0] grp;
    input       member;
    input [1:0] idx;
    begin
      grp_or = member ? |(vec & grp) : vec[idx];
    end
  endfunction

  function [1:0] lowest;
    input [3:0] m;
    begin
      lowest = m[0] ? 2'd0 : m[1] ? 2'd1 : m[2] ? 2'd2 : 2'd3;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [1:0]  boot_ff;
  reg [4:0]  boot_cnt_ff;
  reg        couple_ff;
  reg [3:0]  ocp_en_ff;
  reg [3:0]  entry_mode_ff;
  reg [15:0] delay_ff;
  reg [3:0]  out_req_ff;
  reg [63:0] vset_ff;
  reg [63:0] iset_ff;
  reg [3:0]  set_chg_ff;
  reg [3:0]  clear_ff;
  reg [3:0]  grp_ff;
  reg [3:0]  err_pend_ff;
  reg [5:0]  tick_cnt_ff;
  reg [9:0]  coarse_cnt_ff;
  reg        fine_tick_ff;
  reg        coarse_tick_ff;
  // non-volatile storage: deliberately no reset
  reg        pon_sel_nv;
  reg [3:0]  grp_pend_nv;
  reg [31:0] slot_cfg_nv [0:1];
  reg [63:0] slot_v_nv   [0:1];
  reg [63:0] slot_i_nv   [0:1];
  // bus
  reg        aw_got_ff;
  reg        w_got_ff;
  reg [7:0]  aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0]  w_strb_ff;
  reg [31:0] rd_mux;
  reg        rd_ok;

  wire [27:0] flags_all;
  wire [3:0]  chan_en;
  wire        do_wr  = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire        do_rd  = s_axi_arvalid & ~s_axi_rvalid;
  wire [31:0] wval   = wmerge(32'h0000_0000, w_data_ff, w_strb_ff);
  wire        is_set = ((aw_addr_ff & `OPS_SET_MASK) == `OPS_REG_VSET) |
                       ((aw_addr_ff & `OPS_SET_MASK) == `OPS_REG_ISET);
  wire [1:0]  wch    = aw_addr_ff[3:2];
  wire        multi  = (grp_ff != 4'h0) & ((grp_ff & (grp_ff - 4'h1)) != 4'h0);
  wire [1:0]  lead   = lowest(grp_ff);
  wire [3:0]  grouped = multi ? grp_ff : 4'h0;
  wire        boot_slot = aw_addr_ff == `OPS_REG_SLOT;
  wire        run    = boot_ff == BOOT_RUN;

  assign s_axi_awready  = ~aw_got_ff & ~s_axi_bvalid;
  assign s_axi_wready   = ~w_got_ff & ~s_axi_bvalid;
  assign s_axi_arready  = ~s_axi_rvalid;
  assign out_enable     = chan_en;
  assign vset           = vset_ff;
  assign iset           = iset_ff;
  assign err_indicator  = |err_pend_ff;

  // ----------------------------------------------------------------
  // timebase: fine tick 1 us, coarse tick 1 ms for groups
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff    <= 6'h00;
      coarse_cnt_ff  <= 10'h000;
      fine_tick_ff   <= 1'b0;
      coarse_tick_ff <= 1'b0;
    end else begin
      fine_tick_ff   <= 1'b0;
      coarse_tick_ff <= 1'b0;
      if (tick_cnt_ff == `OPS_TICK_LAST) begin
        tick_cnt_ff  <= 6'h00;
        fine_tick_ff <= 1'b1;
        if (coarse_cnt_ff == `OPS_COARSE_LAST) begin
          coarse_cnt_ff  <= 10'h000;
          coarse_tick_ff <= 1'b1;
        end else begin
          coarse_cnt_ff <= coarse_cnt_ff + 10'h001;
        end
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got_ff    <= 1'b0;
      w_got_ff     <= 1'b0;
      aw_addr_ff   <= 8'h00;
      w_data_ff    <= 32'h0000_0000;
      w_strb_ff    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OPS_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `OPS_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (is_set || aw_addr_ff <= `OPS_REG_REBOOT) ? `OPS_RESP_OKAY : `OPS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `OPS_RESP_OKAY : `OPS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `OPS_REG_CTRL:   rd_mux = {30'h0000_0000, pon_sel_nv, couple_ff};
      `OPS_REG_OCPCFG: rd_mux = {24'h00_0000, entry_mode_ff, ocp_en_ff};
      `OPS_REG_DELAY:  rd_mux = {16'h0000, delay_ff};
      `OPS_REG_OUTPUT: rd_mux = {24'h00_0000, chan_en, out_req_ff};
      `OPS_REG_CLEAR:  rd_mux = 32'h0000_0000;
      `OPS_REG_STATUS: rd_mux = {1'b0, flags_all[27:21], 1'b0, flags_all[20:14],
                                 1'b0, flags_all[13:7], 1'b0, flags_all[6:0]};
      `OPS_REG_SYSST:  rd_mux = {20'h0_0000, grp_pend_nv, grp_ff, 2'b00, run, |err_pend_ff};
      `OPS_REG_ERRQ:   rd_mux = (err_pend_ff == 4'h0) ? 32'h0000_0000 :
                                {24'h00_0000, `OPS_ERR_BASE + {6'h00, lowest(err_pend_ff)}};
      `OPS_REG_SLOT:   rd_mux = 32'h0000_0000;
      `OPS_REG_GROUP:  rd_mux = {28'h000_0000, grp_pend_nv};
      `OPS_REG_REBOOT: rd_mux = 32'h0000_0000;
      default: begin
        if ((s_axi_araddr & `OPS_SET_MASK) == `OPS_REG_VSET)
          rd_mux = {16'h0000, vset_ff[16*s_axi_araddr[3:2] +: 16]};
        else if ((s_axi_araddr & `OPS_SET_MASK) == `OPS_REG_ISET)
          rd_mux = {16'h0000, iset_ff[16*s_axi_araddr[3:2] +: 16]};
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // non-volatile slots, power-on choice and pending groups
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (do_wr && boot_slot && wval[`OPS_SLOT_SAVE]) begin
      // save overwrites the chosen slot whole
      slot_cfg_nv[wval[`OPS_SLOT_SEL]] <= {delay_ff, 7'h00, couple_ff, entry_mode_ff, ocp_en_ff};
      slot_v_nv[wval[`OPS_SLOT_SEL]]   <= vset_ff;
      slot_i_nv[wval[`OPS_SLOT_SEL]]   <= iset_ff;
    end
    if (do_wr && aw_addr_ff == `OPS_REG_CTRL)
      pon_sel_nv <= wval[`OPS_CTRL_PON];
    if (do_wr && aw_addr_ff == `OPS_REG_GROUP)
      grp_pend_nv <= wval[3:0];
  end

  // ----------------------------------------------------------------
  // settings, boot sequence, self-test and error queue
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_ff       <= BOOT_TEST;
      boot_cnt_ff   <= 5'h00;
      couple_ff     <= 1'b0;
      ocp_en_ff     <= 4'h0;
      entry_mode_ff <= 4'h0;
      delay_ff      <= `OPS_DELAY_RST;
      out_req_ff    <= 4'h0;
      vset_ff       <= {4{`OPS_SET_RST}};
      iset_ff       <= {4{`OPS_SET_RST}};
      set_chg_ff    <= 4'h0;
      clear_ff      <= 4'h0;
      grp_ff        <= 4'h0;
      err_pend_ff   <= 4'h0;
    end else begin
      set_chg_ff <= 4'h0;
      clear_ff   <= 4'h0;
      if (do_rd && {s_axi_araddr[7:2], 2'b00} == `OPS_REG_ERRQ)
        err_pend_ff <= err_pend_ff & (err_pend_ff - 4'h1);   // pops the lowest-numbered entry
      case (boot_ff)
        BOOT_TEST: begin
          boot_cnt_ff <= boot_cnt_ff + 5'h01;
          if (boot_cnt_ff == `OPS_SELFTEST_LAST) begin
            err_pend_ff <= selftest_fault;
            grp_ff      <= grp_pend_nv;
            boot_ff     <= BOOT_RECALL;
          end
        end
        BOOT_RECALL: begin
          if (pon_sel_nv) begin
            {delay_ff, couple_ff, entry_mode_ff, ocp_en_ff} <=
              {slot_cfg_nv[0][31:16], slot_cfg_nv[0][8:0]};
            vset_ff <= slot_v_nv[0];
            iset_ff <= slot_i_nv[0];
          end
          boot_ff <= BOOT_RUN;
        end
        BOOT_RUN: begin
          if (do_wr) begin
            case (aw_addr_ff)
              `OPS_REG_CTRL:   couple_ff <= wval[`OPS_CTRL_COUPLE];
              `OPS_REG_OCPCFG: {entry_mode_ff, ocp_en_ff} <= wval[7:0];
              `OPS_REG_DELAY:  delay_ff <= wval[15:0];
              `OPS_REG_OUTPUT: begin
                out_req_ff <= wval[3:0];
                set_chg_ff <= wval[3:0] ^ out_req_ff;
              end
              `OPS_REG_CLEAR:  clear_ff <= wval[3:0];
              `OPS_REG_SLOT: begin
                if (wval[`OPS_SLOT_RECALL]) begin
                  {delay_ff, couple_ff, entry_mode_ff, ocp_en_ff} <=
                    {slot_cfg_nv[wval[0]][31:16], slot_cfg_nv[wval[0]][8:0]};
                  vset_ff    <= slot_v_nv[wval[`OPS_SLOT_SEL]];
                  iset_ff    <= slot_i_nv[wval[`OPS_SLOT_SEL]];
                  set_chg_ff <= 4'hF;
                end
              end
              `OPS_REG_REBOOT: begin
                if (wval[0]) begin
                  // reboot reapplies defaults, reruns self-test, latches groups
                  boot_ff       <= BOOT_TEST;
                  boot_cnt_ff   <= 5'h00;
                  couple_ff     <= 1'b0;
                  ocp_en_ff     <= 4'h0;
                  entry_mode_ff <= 4'h0;
                  delay_ff      <= `OPS_DELAY_RST;
                  out_req_ff    <= 4'h0;
                  vset_ff       <= {4{`OPS_SET_RST}};
                  iset_ff       <= {4{`OPS_SET_RST}};
                  clear_ff      <= 4'hF;
                end
              end
              default: begin
                if ((aw_addr_ff & `OPS_SET_MASK) == `OPS_REG_VSET) begin
                  vset_ff[16*wch +: 16] <= wval[15:0];
                  set_chg_ff[wch]       <= 1'b1;
                end else if ((aw_addr_ff & `OPS_SET_MASK) == `OPS_REG_ISET) begin
                  iset_ff[16*wch +: 16] <= wval[15:0];
                  set_chg_ff[wch]       <= 1'b1;
                end
              end
            endcase
          end
        end
        default: boot_ff <= BOOT_TEST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // channels; grouped members follow the lead's settings
  // ----------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < 4; n = n + 1) begin : g_chan
      wire [1:0] src     = grouped[n] ? lead : n[1:0];
      wire [3:0] others  = flags_cause_mask(n);
      wire       coupled = couple_ff & |others;
      assign prot_indicator[n] = |flags_all[7*n +: 7];

      ops_chan u_chan (
        .clk                       (clk),
        .rst                       (rst),
        .out_req                   (out_req_ff[src] & run),
        .ocp_en                    (ocp_en_ff[src]),
        .delay_on_regulation_entry (entry_mode_ff[src]),
        .delay                     (delay_ff),
        .tick                      (grouped[n] ? coarse_tick_ff : fine_tick_ff),
        .set_chg                   (set_chg_ff[src]),
        .clear                     (clear_ff[src]),
        .current_regulation_state  (grp_or(current_regulation_state, grp_ff, grouped[n], n[1:0])),
        .overvoltage_guard         (grp_or(overvoltage_guard, grp_ff, grouped[n], n[1:0])),
        .overtemp                  (grp_or(overtemp, grp_ff, grouped[n], n[1:0])),
        .mains_fail                (grp_or(mains_fail, grp_ff, grouped[n], n[1:0])),
        .power_limit               (grp_or(power_limit, grp_ff, grouped[n], n[1:0])),
        .external_shutdown         (grp_or(external_shutdown, grp_ff, grouped[n], n[1:0])),
        .coupled_trip              (coupled),
        .flags_ff                  (flags_all[7*n +: 7]),
        .out_en_ff                 (chan_en[n])
      );
    end
  endgenerate

  // own-cause trips of the other channels; the coupled flag itself never spreads
  function [3:0] flags_cause_mask;
    input integer self;
    integer k;
    begin
      flags_cause_mask = 4'h0;
      for (k = 0; k < 4; k = k + 1)
        if (k != self)
          flags_cause_mask[k] = |(flags_all[7*k +: 7] & 7'h5F);
    end
  endfunction

endmodule

// file: tb/ops_chk.sv
// checker: bus handshake and protection assertions on the supervisor top
`timescale 1ns/1ns
module ops_chk (
  // clock and reset
  input logic        clk,
  input logic        rst,
  // bus handshakes
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // channel side
  input logic [3:0]  overvoltage_guard,
  input logic [3:0]  overtemp,
  input logic [3:0]  out_enable,
  input logic [3:0]  prot_indicator
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [2:0] bv_hist_ff;
  // channel 1's flag may only fall, or its output rise, shortly after a write answer
  always_ff @(posedge clk or posedge rst)
    if (rst) bv_hist_ff <= 3'h0;
    else bv_hist_ff <= {bv_hist_ff[1:0], s_axi_bvalid};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ov_kills_out: assert property (overvoltage_guard[1] |=> !out_enable[1])
    else $error("overvoltage left output on");
  a_temp_kills_out: assert property (overtemp[2] |=> !out_enable[2])
    else $error("overtemp left output on");
  a_flag_holds_off: assert property ((prot_indicator & out_enable) == 4'h0)
    else $error("output on with a fault flag");
  a_flag_latched: assert property ($fell(prot_indicator[1]) |-> |bv_hist_ff)
    else $error("flag dropped without a write");
  a_out_on_clear: assert property ($rose(out_enable[1]) |-> |bv_hist_ff)
    else $error("output came back without a write");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  a_wr_answers: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_rd_answers: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  c_trip: cover property ($fell(out_enable[3]));
  c_all_off: cover property (out_enable == 4'h0 && prot_indicator == 4'hF);
  c_errq_head: cover property (s_axi_rvalid && s_axi_rdata == 32'h0000_0012);
endmodule
bind ops_top ops_chk u_chk (.*);

// file: tb/ops_tb_top.sv
// self-checking bench for the output protection supervisor
`timescale 1ns/1ns
module ops_tb_top;
  logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, err_indicator;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb, current_regulation_state, overvoltage_guard, overtemp, mains_fail, power_limit;
  logic [3:0]  external_shutdown, selftest_fault, out_enable, prot_indicator;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp_q;
  logic [63:0] vset, iset;
  int          err_total, checks_done, cyc;
  ops_top dut (.*);
  // ----------------------------------------
  // clock, watchdog, helpers
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 20000) begin
        err_total++;
        conclude();
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // handshakes are judged at the falling edge, so the rising edge never races the design
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, pr, fin;
    fin = 0;
    @(posedge clk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
    end
    while (!fin) begin
      @(negedge clk);
      pa = w ? s_axi_awvalid & s_axi_awready : s_axi_arvalid & s_axi_arready;
      pw = s_axi_wvalid & s_axi_wready;
      pr = w ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
      rd_q = s_axi_rdata;
      rsp_q = w ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      if (pa) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (pw) s_axi_wvalid <= 0;
      if (pr) {s_axi_bready, s_axi_rready} <= 2'b00;
      if (pr) fin = 1;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    xfer(0, a, 32'h0000_0000);
    chk(rd_q, exp, m);
  endtask
  task automatic ochk(input logic [3:0] exp, input string m);
    @(negedge clk);
    chk(out_enable, exp, m);
  endtask
  task automatic cause(input int k, input logic [3:0] v);
    case (k)
      0: overvoltage_guard <= v;
      2: overtemp <= v;
      3: mains_fail <= v;
      4: power_limit <= v;
      6: external_shutdown <= v;
      default: current_regulation_state <= v;
    endcase
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // stored groups are unknown at power-on: define them, then reboot so they apply
  task automatic t_init();
    xfer(1, 8'h00, 32'h0000_0000);
    xfer(1, 8'h24, 32'h0000_0000);
    xfer(1, 8'h28, 32'h0000_0001);
    repeat (20) @(posedge clk);
    rchk(8'h18, 32'h0000_0002, "boot runs");
    rchk(8'h14, 32'h0000_0000, "status at reset");
    xfer(0, 8'h2C, 32'h0000_0000);
    chk(rsp_q, 2'b10, "unmapped read");
    xfer(1, 8'h0C, 32'h0000_000F);
    $display("init done");
  endtask
  task automatic t_causes();
    for (int k = 0; k < 7; k++) begin
      if (k == 1 || k == 5) continue;
      cause(k, 4'h2);
      repeat (2) @(posedge clk);
      cause(k, 4'h0);
      ochk(4'hD, "cause trip");
      rchk(8'h14, 32'h0000_0100 << k, "cause flag");
      xfer(1, 8'h10, 32'h0000_0002);
      repeat (3) @(posedge clk);
      ochk(4'hF, "clear");
    end
    $display("causes done");
  endtask
  task automatic t_couple();
    xfer(1, 8'h00, 32'h0000_0001);
    cause(2, 4'h4);
    repeat (3) @(posedge clk);
    cause(2, 4'h0);
    ochk(4'h0, "coupled off");
    rchk(8'h14, 32'h2004_2020, "coupled flags");
    xfer(1, 8'h00, 32'h0000_0000);
    xfer(1, 8'h10, 32'h0000_000F);
    repeat (3) @(posedge clk);
    ochk(4'hF, "all restored");
    $display("couple done");
  endtask
  task automatic t_ocp();
    xfer(1, 8'h08, 32'h0000_0002);
    xfer(1, 8'h04, 32'h0000_0088);
    cause(1, 4'h8);
    repeat (40) @(posedge clk);
    cause(1, 4'h0);
    ochk(4'hF, "brief regulation");
    @(posedge clk);
    cause(1, 4'h8);
    repeat (200) @(posedge clk);
    ochk(4'h7, "entry trip");
    rchk(8'h14, 32'h0200_0000, "overcurrent flag");
    cause(1, 4'h0);
    xfer(1, 8'h04, 32'h0000_0008);
    xfer(1, 8'h10, 32'h0000_0008);
    xfer(1, 8'h4C, 32'h0000_0010);
    cause(1, 4'h8);
    repeat (40) @(posedge clk);
    ochk(4'hF, "setting start");
    repeat (200) @(posedge clk);
    ochk(4'h7, "setting trip");
    @(posedge clk);
    cause(1, 4'h0);
    xfer(1, 8'h04, 32'h0000_0000);
    xfer(1, 8'h10, 32'h0000_0008);
    $display("guard done");
  endtask
  task automatic t_slot_boot();
    xfer(1, 8'h30, 32'h0000_1234);
    xfer(1, 8'h20, 32'h0000_0003);
    xfer(1, 8'h30, 32'h0000_5555);
    xfer(1, 8'h20, 32'h0000_0005);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(vset[15:0], 16'h1234, "recall");
    xfer(1, 8'h24, 32'h0000_0006);
    @(posedge clk);
    selftest_fault <= 4'h4;
    xfer(1, 8'h28, 32'h0000_0001);
    repeat (25) @(posedge clk);
    @(negedge clk);
    chk(err_indicator, 1'b1, "self-test error");
    chk(vset[15:0], 16'h0000, "defaults");
    rchk(8'h18, 32'h0000_0663, "groups latched");
    rchk(8'h1C, 32'h0000_0012, "queue head");
    rchk(8'h1C, 32'h0000_0000, "queue empty");
    xfer(1, 8'h0C, 32'h0000_000F);
    cause(2, 4'h4);
    repeat (2) @(posedge clk);
    cause(2, 4'h0);
    ochk(4'h9, "group trip");
    $display("slots and boot done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, current_regulation_state, overvoltage_guard, overtemp, mains_fail, power_limit} = '0;
    {external_shutdown, selftest_fault, err_total, checks_done} = '0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge clk);
    rst <= 0;
    repeat (20) @(posedge clk);
    t_init();
    t_causes();
    t_couple();
    t_ocp();
    t_slot_boot();
    conclude();
  end
endmodule
